// ==== design/sync_mem_port.sv ====
// programmable synchronous memory port: sram or fifo with glue logic
// assumes: link_clk is the external clock picked by clk_select_out,
// free running; one access in flight at a time
//
// Functional notes
// [R1] read latency zero to three cycles
// [R2] write latency zero to three cycles
// [R3] no extension: select drops after command
// [R4] extension: select follows output enable exactly; on writes the code drops select after the command with output enable high
// [R5] strobe mode: address strobe plus deselect
// [R6] fifo mode: read enable, no deselect
// [R7] interface clocked by selected clock output
// [R8] shared pins act as strobe, oe, we
// [R9] settings held independently per space
// [R10] launch and capture on rising edge
// [R11] memory returns data after read latency
// [R12] write data follows write enable by latency
`default_nettype none

module sync_mem_port (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // selected external clock, drives the link logic
  input wire logic link_clk,
  // per-space secondary control settings
  input wire sync_mem_pkg::space_cfg_s [sync_mem_pkg::SPACES-1:0]
    space_secondary_control,
  // request and answer
  input wire logic req_valid,
  input wire sync_mem_pkg::mem_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [sync_mem_pkg::DATA_W-1:0] rsp_data,
  // clock select toward the external clock mux
  output logic clk_select_out,
  // memory pins, all strobes active low
  output logic [sync_mem_pkg::SPACES-1:0] space_select_n,
  output logic addr_strobe_or_read_enable_n,
  output logic sync_output_enable_n,
  output logic sync_write_enable_n,
  output logic [sync_mem_pkg::ADDR_W-1:0] ext_address_bus,
  output logic [sync_mem_pkg::BE_W-1:0] ext_byte_enable_n,
  // two-way data bus
  input wire logic [sync_mem_pkg::DATA_W-1:0] ext_data_in,
  output logic [sync_mem_pkg::DATA_W-1:0] ext_data_out,
  output logic ext_data_oe
);

  sync_mem_pkg::sys_st_s sys_q; // system-side state
  sync_mem_pkg::sys_st_s sys_d;
  sync_mem_pkg::link_st_s lnk_q; // link-side state
  sync_mem_pkg::link_st_s lnk_d;
  logic req_sync; // request toggle seen in link domain
  logic ack_sync; // done toggle seen in system domain
  sync_mem_pkg::space_cfg_s cfg_l; // settings of the access in flight
  logic finish; // last link cycle of an access

  // space number to active-low select
  function automatic logic [sync_mem_pkg::SPACES-1:0] select_of(
    input logic [sync_mem_pkg::SPACE_W-1:0] space);
    logic [sync_mem_pkg::SPACES-1:0] sel;
    sel = sync_mem_pkg::SELECT_IDLE;
    sel[space] = 1'b0;
    return sel;
  endfunction

  // toggle crossings; command word stays still while a toggle is open
  sync_bit u_req_sync (
    .clk(link_clk),
    .rst(rst),
    .d(sys_q.req_tgl),
    .q(req_sync)
  );

  sync_bit u_ack_sync (
    .clk(clk_sys),
    .rst(rst),
    .d(lnk_q.ack_tgl),
    .q(ack_sync)
  );

  // system side: take a request, snapshot its space settings
  always_comb begin
    sys_d = sys_q;
    sys_d.rsp_valid = 1'b0;
    if (sys_q.ready && req_valid) begin
      sys_d.cmd.req = req;
      sys_d.cmd.cfg = space_secondary_control[req.space]; // [R9]
      sys_d.clk_sel =
        space_secondary_control[req.space].sync_clock_select; // [R7]
      sys_d.req_tgl = ~sys_q.req_tgl;
      sys_d.ready = 1'b0;
    end
    // done: read data was registered on the same link edge that flipped the toggle
    if (!sys_q.ready && (ack_sync != sys_q.ack_seen)) begin
      sys_d.ack_seen = ack_sync;
      sys_d.ready = 1'b1;
      sys_d.rsp_valid = 1'b1;
      sys_d.rsp_data = lnk_q.rdata;
    end
  end

  // system registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_q <= '0;
      sys_q.ready <= 1'b1;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign cfg_l = sys_q.cmd.cfg;

  // link sequencer: every pin launches from a rising edge
  always_comb begin
    lnk_d = lnk_q;
    finish = 1'b0;
    unique case (lnk_q.state)
      sync_mem_pkg::LK_IDLE: begin
        if (req_sync != lnk_q.req_seen) begin
          lnk_d.req_seen = req_sync;
          lnk_d.cs_n = select_of(sys_q.cmd.req.space); // [R10]
          // fifo mode pulses read enable on reads only
          lnk_d.strobe_n = cfg_l.read_enable_mode
            & sys_q.cmd.req.write; // [R8]
          lnk_d.oe_n = sys_q.cmd.req.write; // [R8]
          lnk_d.we_n = ~sys_q.cmd.req.write; // [R8]
          lnk_d.addr = sys_q.cmd.req.addr;
          lnk_d.be_n = ~sys_q.cmd.req.be;
          lnk_d.dout = sys_q.cmd.req.data;
          // zero write latency puts data out with the command
          lnk_d.dout_oe = sys_q.cmd.req.write
            && (cfg_l.write_latency_sel == sync_mem_pkg::LAT_ZERO); // [R2]
          if (sys_q.cmd.req.write) begin
            lnk_d.cnt = cfg_l.write_latency_sel; // [R2]
            lnk_d.state = sync_mem_pkg::LK_WRITE;
          end else begin
            lnk_d.cnt = cfg_l.read_latency_sel; // [R1]
            lnk_d.state = sync_mem_pkg::LK_READ;
          end
        end
      end
      sync_mem_pkg::LK_READ: begin
        lnk_d.strobe_n = 1'b1;
        // without extension the select ends with the command
        if (!cfg_l.select_extend) begin
          lnk_d.cs_n = sync_mem_pkg::SELECT_IDLE; // [R3]
        end
        if (lnk_q.cnt == sync_mem_pkg::LAT_ZERO) begin
          lnk_d.rdata = ext_data_in; // [R10] [R11]
          lnk_d.oe_n = 1'b1;
          lnk_d.cs_n = sync_mem_pkg::SELECT_IDLE; // [R4]
          finish = 1'b1;
        end else begin
          lnk_d.cnt = lnk_q.cnt - sync_mem_pkg::LAT_ONE; // [R1]
        end
      end
      sync_mem_pkg::LK_WRITE: begin
        lnk_d.strobe_n = 1'b1;
        lnk_d.we_n = 1'b1;
        lnk_d.cs_n = sync_mem_pkg::SELECT_IDLE; // [R3]
        if (lnk_q.cnt == sync_mem_pkg::LAT_ZERO) begin
          lnk_d.dout_oe = 1'b0;
          finish = 1'b1;
        end else begin
          // data goes out exactly latency edges after the command
          lnk_d.dout_oe = (lnk_q.cnt == sync_mem_pkg::LAT_ONE); // [R12]
          lnk_d.cnt = lnk_q.cnt - sync_mem_pkg::LAT_ONE;
        end
      end
      sync_mem_pkg::LK_DESEL: begin
        // one idle cycle with every select high
        lnk_d.state = sync_mem_pkg::LK_IDLE; // [R5]
      end
      default: begin
        lnk_d.state = sync_mem_pkg::LK_IDLE;
      end
    endcase
    if (finish) begin
      lnk_d.ack_tgl = ~lnk_q.ack_tgl;
      // fifo mode skips the deselect cycle
      if (cfg_l.read_enable_mode) begin
        lnk_d.state = sync_mem_pkg::LK_IDLE; // [R6]
      end else begin
        lnk_d.state = sync_mem_pkg::LK_DESEL; // [R5]
      end
    end
  end

  // link registers on the selected clock
  always_ff @(posedge link_clk or posedge rst) begin // [R7]
    if (rst) begin
      lnk_q <= '0;
      lnk_q.state <= sync_mem_pkg::LK_IDLE;
      lnk_q.cs_n <= sync_mem_pkg::SELECT_IDLE;
      lnk_q.strobe_n <= 1'b1;
      lnk_q.oe_n <= 1'b1;
      lnk_q.we_n <= 1'b1;
      lnk_q.be_n <= sync_mem_pkg::BE_IDLE;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // outputs straight from registers
  assign req_ready = sys_q.ready;
  assign rsp_valid = sys_q.rsp_valid;
  assign rsp_data = sys_q.rsp_data;
  assign clk_select_out = sys_q.clk_sel;
  assign space_select_n = lnk_q.cs_n;
  assign addr_strobe_or_read_enable_n = lnk_q.strobe_n;
  assign sync_output_enable_n = lnk_q.oe_n;
  assign sync_write_enable_n = lnk_q.we_n;
  assign ext_address_bus = lnk_q.addr;
  assign ext_byte_enable_n = lnk_q.be_n;
  assign ext_data_out = lnk_q.dout;
  assign ext_data_oe = lnk_q.dout_oe;

  // link-domain checks
  sel_extend_a: assert property (@(posedge link_clk) disable iff (rst) // [R4]
    (cfg_l.select_extend && !lnk_q.oe_n) |-> (lnk_q.cs_n != '1))
    else $error("select dropped while output enable active");
  // the command cycle itself still shows the select, so start one later
  sel_drop_a: assert property (@(posedge link_clk) disable iff (rst) // [R3]
    (!cfg_l.select_extend && lnk_q.state == sync_mem_pkg::LK_READ
      && $past(lnk_q.state) == sync_mem_pkg::LK_READ)
      |-> (lnk_q.cs_n == '1))
    else $error("select held past command without extension");
  rd_lat_a: assert property (@(posedge link_clk) disable iff (rst) // [R1]
    ($fell(lnk_q.oe_n) && cfg_l.read_latency_sel == 2'h2)
      |-> !lnk_q.oe_n [*3] ##1 lnk_q.oe_n)
    else $error("read window length wrong for latency two");
  wr_lat1_a: assert property (@(posedge link_clk) disable iff (rst) // [R12]
    ($fell(lnk_q.we_n) && cfg_l.write_latency_sel == 2'h1)
      |-> !lnk_q.dout_oe ##1 lnk_q.dout_oe ##1 !lnk_q.dout_oe)
    else $error("write data not one cycle after write enable");
  wr_lat0_a: assert property (@(posedge link_clk) disable iff (rst) // [R2]
    ($fell(lnk_q.we_n) && cfg_l.write_latency_sel == 2'h0)
      |-> lnk_q.dout_oe ##1 !lnk_q.dout_oe)
    else $error("write data not with write enable");
  // judged on the finishing edge: once the done toggle is out the system
  // side may load the next command, so the settings are no longer ours
  desel_a: assert property (@(posedge link_clk) disable iff (rst) // [R5]
    (finish && !cfg_l.read_enable_mode)
      |=> lnk_q.state == sync_mem_pkg::LK_DESEL ##1
        (lnk_q.cs_n == '1 && lnk_q.strobe_n))
    else $error("deselect cycle missing");
  fifo_nodesel_a: assert property (@(posedge link_clk) disable iff (rst)
    (finish && cfg_l.read_enable_mode) // [R6]
      |=> lnk_q.state == sync_mem_pkg::LK_IDLE)
    else $error("deselect inserted in fifo mode");
  pin_role_a: assert property (@(posedge link_clk) disable iff (rst) // [R8]
    !lnk_q.we_n |-> (lnk_q.oe_n && lnk_q.cs_n != '1))
    else $error("write enable without select or with output enable");
  // system-domain check
  clk_sel_a: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
    (req_valid && sys_q.ready) |=> (sys_q.clk_sel ==
      $past(space_secondary_control[req.space].sync_clock_select)))
    else $error("clock select not taken from the space settings");

  rd_c: cover property (@(posedge link_clk) disable iff (rst)
    $rose(lnk_q.oe_n) && lnk_q.state == sync_mem_pkg::LK_DESEL);
  wr_c: cover property (@(posedge link_clk) disable iff (rst)
    $fell(lnk_q.we_n) ##[1:4] lnk_q.dout_oe);
  fifo_c: cover property (@(posedge link_clk) disable iff (rst)
    cfg_l.select_extend && cfg_l.read_enable_mode && !lnk_q.strobe_n);

endmodule // sync_mem_port

`default_nettype wire

// ==== design/sync_mem_pkg.sv ====
// constants, types and state records for the synchronous memory port
// assumes: a single system clock domain plus one selected link clock
`default_nettype none

package sync_mem_pkg;

  // geometry of the port
  localparam int SPACES = 4;
  localparam int SPACE_W = 2;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 64;
  localparam int BE_W = 8;
  localparam int LAT_W = 2;

  // values after reset and idle pin levels
  localparam logic [SPACES-1:0] SELECT_IDLE = 4'hF;
  localparam logic [LAT_W-1:0] LAT_ZERO = 2'h0;
  localparam logic [LAT_W-1:0] LAT_ONE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h0_0000;
  localparam logic [BE_W-1:0] BE_IDLE = 8'hFF;
  localparam logic [DATA_W-1:0] DATA_RESET = 64'h0000_0000_0000_0000;

  // per-space secondary control settings
  typedef struct packed {
    logic [LAT_W-1:0] read_latency_sel;
    logic [LAT_W-1:0] write_latency_sel;
    logic select_extend;
    logic read_enable_mode;
    logic sync_clock_select;
  } space_cfg_s;

  // one access request from the system side
  typedef struct packed {
    logic write;
    logic [SPACE_W-1:0] space;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be;
    logic [DATA_W-1:0] data;
  } mem_req_s;

  // request plus the settings of its space, held across the crossing
  typedef struct packed {
    space_cfg_s cfg;
    mem_req_s req;
  } link_cmd_s;

  // link sequencer states, one-hot
  typedef enum logic [3:0] {
    LK_IDLE = 4'h1,
    LK_READ = 4'h2,
    LK_WRITE = 4'h4,
    LK_DESEL = 4'h8
  } link_state_e;

  // link-side state record
  typedef struct packed {
    link_state_e state;
    logic [LAT_W-1:0] cnt;
    logic ack_tgl;
    logic req_seen;
    logic [SPACES-1:0] cs_n;
    logic strobe_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0] be_n;
    logic [DATA_W-1:0] dout;
    logic dout_oe;
    logic [DATA_W-1:0] rdata;
  } link_st_s;

  // system-side state record
  typedef struct packed {
    link_cmd_s cmd;
    logic req_tgl;
    logic ack_seen;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic clk_sel;
  } sys_st_s;

  // two-stage synchroniser record
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_stages_s;

endpackage

`default_nettype wire

// ==== design/sync_bit.sv ====
// two flip-flop level synchroniser
// assumes: d is a level from another clock domain, rst asynchronous
`default_nettype none

module sync_bit (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst,
  // level in and synchronised level out
  input wire logic d,
  output logic q
);

  sync_mem_pkg::sync_stages_s st_q; // both stages
  sync_mem_pkg::sync_stages_s st_d; // next stages

  // the first stage feeds only the second stage
  always_comb begin
    st_d.meta = d;
    st_d.stable = st_q.meta;
  end

  // registers of both stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.stable;

endmodule // sync_bit

`default_nettype wire

// ==== sim/sync_mem_model.sv ====
// behavioural synchronous memory standing on the far side of the port
// assumes: rl and wl match the space now being accessed, one access
// at a time, bus released between transfers
`default_nettype none

module sync_mem_model (
  // link clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // control pins from the port, active low
  input wire logic [3:0] cs_n,
  input wire logic strobe_n,
  input wire logic we_n,
  input wire logic [19:0] addr,
  input wire logic [7:0] be_n,
  // write side of the data bus
  input wire logic [63:0] dout,
  input wire logic doe,
  // latencies of the selected space
  input wire logic [1:0] rl,
  input wire logic [1:0] wl,
  // read side of the data bus
  output logic [63:0] din
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [63:0] mem [0:63]; // word store, low six address bits used
  logic [63:0] dreg; // registered side of the read bus
  int rc = 0; // edges left until read data is launched
  int wc = 0; // edges left until write data is taken
  logic [19:0] ra, wa;
  logic [7:0] wbe;
  logic cmd;

  // a command is any selected edge with strobe or write enable low
  assign cmd = ~&cs_n && (!strobe_n || !we_n);
  // zero latency flows the word through while the read command stands
  assign din = (cmd && we_n && rl == 2'h0) ? mem[addr[5:0]] : dreg;
  initial begin
    dreg = 64'h0000_0000_0000_0000;
    foreach (mem[i]) mem[i] = 64'h0000_0000_0000_0000;
  end

  // all sampling on the rising link edge
  always @(posedge link_clk) begin
    if (rst) begin
      rc = 0;
      wc = 0;
    end else begin
      // the edge that sees the write counts as latency zero
      if (cmd && !we_n) begin
        wc = wl + 1;
        wa = addr;
        wbe = ~be_n;
      end
      // an undriven bus reads as garbage, not as the last value
      if (wc == 1) begin
        for (int i = 0; i < 8; i++)
          if (wbe[i])
            mem[wa[5:0]][8*i+:8] = doe ? dout[8*i+:8] : ~dout[8*i+:8];
      end
      if (wc > 0) wc--;
      if (cmd && we_n) begin
        rc = rl;
        ra = addr;
      end
      // word launched here stands only at the capture edge
      if (rc == 1) dreg <= mem[ra[5:0]];
      else dreg <= ~dreg;
      if (rc > 0) rc--;
    end
  end
endmodule // sync_mem_model

`default_nettype wire

// ==== sim/sync_mem_port_tb.sv ====
// self-checking bench for the synchronous memory port
// assumes: memory model on the pins, link clock 64 ns, free running
`default_nettype none

module sync_mem_port_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // clocks, reset and system side
  logic clk_sys = 0, link_clk = 0, rst = 1, req_valid = 0;
  sync_mem_pkg::space_cfg_s [3:0] cfg;
  sync_mem_pkg::mem_req_s req = '0;
  logic req_ready, rsp_valid, clk_select_out;
  logic [63:0] rsp_data, din, dout;
  // pins
  logic [3:0] cs_n;
  logic strobe_n, oe_n, we_n, doe;
  logic [19:0] addr, cap_addr;
  logic [7:0] be_n, cap_be;
  logic [3:0] cap_cs;
  logic [1:0] m_rl = 0, m_wl = 0;
  int error_cnt = 0, total_checks = 0, cyc = 0, lk = 0;
  int cs_cnt = 0, oe_cnt = 0, st_cnt = 0, we_at = 0, doe_at = -1;

  sync_mem_port sync_mem_port_i (.clk_sys(clk_sys), .rst(rst),
    .link_clk(link_clk), .space_secondary_control(cfg),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .clk_select_out(clk_select_out), .space_select_n(cs_n),
    .addr_strobe_or_read_enable_n(strobe_n),
    .sync_output_enable_n(oe_n), .sync_write_enable_n(we_n),
    .ext_address_bus(addr), .ext_byte_enable_n(be_n),
    .ext_data_in(din), .ext_data_out(dout), .ext_data_oe(doe));

  sync_mem_model sync_mem_model_i (.link_clk(link_clk), .rst(rst),
    .cs_n(cs_n), .strobe_n(strobe_n), .we_n(we_n), .addr(addr),
    .be_n(be_n), .dout(dout), .doe(doe), .rl(m_rl), .wl(m_wl),
    .din(din));

  // clocks: phase offset keeps the domains unrelated
  initial forever #2.5 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #32 link_clk = ~link_clk;
  end

  // pin monitor: counts low cycles and notes the first command
  always @(posedge link_clk) begin
    lk++;
    if (~&cs_n) begin
      if (cs_cnt == 0) begin
        cap_cs = cs_n;
        cap_addr = addr;
        cap_be = be_n;
      end
      cs_cnt++;
    end
    if (!oe_n) oe_cnt++;
    if (!strobe_n) st_cnt++;
    if (!we_n) we_at = lk;
    if (doe && doe_at < 0) doe_at = lk;
  end

  // hang guard, far above the expected thousand or so cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one access, driven just after an edge and held for one system edge
  task automatic access(input logic w, input int s, input logic [19:0] a,
                        input logic [7:0] be, input logic [63:0] d);
    int n;
    m_rl = cfg[s].read_latency_sel;
    m_wl = cfg[s].write_latency_sel;
    cs_cnt = 0;
    oe_cnt = 0;
    st_cnt = 0;
    doe_at = -1;
    @(posedge clk_sys);
    #1;
    req = '{write: w, space: s[1:0], addr: a, be: be, data: d};
    req_valid = 1;
    @(posedge clk_sys);
    #1;
    req_valid = 0;
    check("req_busy", 64'(req_ready), 64'h0);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 1000);
    check("rsp_valid", 64'(rsp_valid), 64'h1);
  endtask

  // full write then a lower-half byte write, pins judged per space
  task automatic t_write(input int s);
    logic [63:0] d;
    d = 64'h0123_4567_89AB_CDEF ^ {16{4'(s)}};
    access(1, s, 20'(16 * s + 3), 8'hFF, d);
    check("wr_data_dly", 64'(doe_at - we_at), 64'(m_wl));
    check("wr_strobe", 64'(st_cnt),
      cfg[s].read_enable_mode ? 64'h0 : 64'h1);
    check("wr_select", 64'(cap_cs), 64'(4'(~(4'h1 << s))));
    check("wr_addr", 64'(cap_addr), 64'(16 * s + 3));
    check("clk_select", 64'(clk_select_out),
      64'(cfg[s].sync_clock_select));
    access(1, s, 20'(16 * s + 3), 8'h0F, ~d);
    check("wr_be", 64'(cap_be), 64'hF0);
  endtask

  // read back the merged word, latency and select length judged
  task automatic t_read(input int s);
    logic [63:0] d;
    d = 64'h0123_4567_89AB_CDEF ^ {16{4'(s)}};
    access(0, s, 20'(16 * s + 3), 8'hFF, 64'h0000_0000_0000_0000);
    check("rd_data", rsp_data, {d[63:32], ~d[31:0]});
    check("rd_oe_len", 64'(oe_cnt), 64'(m_rl + 1));
    check("rd_cs_len", 64'(cs_cnt),
      cfg[s].select_extend ? 64'(m_rl + 1) : 64'h1);
    check("rd_strobe", 64'(st_cnt), 64'h1);
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // each space gets its own latencies, extension and strobe mode
  initial begin
    for (int s = 0; s < 4; s++) begin
      cfg[s].read_latency_sel = 2'(s);
      cfg[s].write_latency_sel = 2'(3 - s);
      cfg[s].select_extend = s[0];
      cfg[s].read_enable_mode = s[1];
      cfg[s].sync_clock_select = s[0];
    end
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 0;
    // let the synchronisers settle before the first request
    repeat (4) @(posedge link_clk);
    check("idle_select", 64'(cs_n), 64'hF);
    for (int s = 0; s < 4; s++) begin
      t_write(s);
      t_read(s);
    end
    print_verdict();
  end
endmodule // sync_mem_port_tb

`default_nettype wire
